// >>> common/urs_pkg.sv
// Package for the reset-state and flow character register bank
package urs_pkg;

	// ==========================================================
	// Register byte addresses (APB word aligned)
	localparam logic [7:0] ADDR_RESUME1     = 8'h00;
	localparam logic [7:0] ADDR_RESUME2     = 8'h04;
	localparam logic [7:0] ADDR_PAUSE1      = 8'h08;
	localparam logic [7:0] ADDR_PAUSE2      = 8'h0c;
	localparam logic [7:0] ADDR_DIV_LOW     = 8'h10;
	localparam logic [7:0] ADDR_DIV_HIGH    = 8'h14;
	localparam logic [7:0] ADDR_FRAC_DIV    = 8'h18;
	localparam logic [7:0] ADDR_INT_EN      = 8'h1c;
	localparam logic [7:0] ADDR_INT_STAT    = 8'h20;
	localparam logic [7:0] ADDR_FIFO_CTRL   = 8'h24;
	localparam logic [7:0] ADDR_LINE_CTRL   = 8'h28;
	localparam logic [7:0] ADDR_MODEM_CTRL  = 8'h2c;
	localparam logic [7:0] ADDR_LINE_STAT   = 8'h30;
	localparam logic [7:0] ADDR_MODEM_STAT  = 8'h34;
	localparam logic [7:0] ADDR_SCRATCH     = 8'h38;
	localparam logic [7:0] ADDR_ENH_MODE    = 8'h3c;
	localparam logic [7:0] ADDR_FEATURE     = 8'h40;
	localparam logic [7:0] ADDR_BUS_MODE    = 8'h44;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_DIV_LOW   = 8'h01;
	localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
	localparam logic [7:0] RST_INT_STAT  = 8'h01;
	localparam logic [7:0] RST_LINE_STAT = 8'h60;
	localparam logic [7:0] RST_SCRATCH   = 8'hff;
	localparam logic [7:0] RST_ENH_MODE  = 8'h80;
	localparam logic [7:0] RST_ZERO      = 8'h00;

	// ==========================================================
	// Field positions and enhanced-bit masks
	localparam int         ENH_EN_BIT     = 4;
	localparam logic [7:0] MASK_INT_EN    = 8'hf0;
	localparam logic [7:0] MASK_INT_STAT  = 8'h30;
	localparam logic [7:0] MASK_FIFO_CTRL = 8'h30;
	localparam logic [7:0] MASK_MODEM_CTL = 8'he0;

	// Host bus styles: strobe pair or chip-select with read/write
	typedef enum logic {URS_BUS_STROBE, URS_BUS_CSRW} urs_bus_e;

	// APB request carrier
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} urs_apb_req_s;

	// Writable register set
	typedef struct packed {
		logic [7:0] resume1;
		logic [7:0] resume2;
		logic [7:0] pause1;
		logic [7:0] pause2;
		logic [7:0] frac_div;
		logic [7:0] int_en;
		logic [7:0] int_stat;
		logic [7:0] fifo_ctrl;
		logic [7:0] line_ctrl;
		logic [7:0] modem_ctrl;
		logic [7:0] line_stat;
		logic [7:0] scratch;
		logic [7:0] enh_mode;
		logic [7:0] feature;
		logic       bus_mode;
	} urs_regs_s;

endpackage

// >>> core/urs_bank.sv
// Reset-state register bank with flow control characters, APB slave
//
// Operation
// [RULE1] Four read/write resume and pause characters
// [RULE2] Divisor loads 0x01/0x00 only at power-up
// [RULE3] Modem status: deltas cleared, upper inverted pins
// [RULE4] Interrupt pin: float or high by style
// [RULE5] Serial out high; differential lines low
// [RULE6] Other registers take documented reset values
// [RULE7] Enhanced bits cleared, locked while disabled
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module urs_bank
	import urs_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        power_on_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [3:0]  modem_in_pins,
	input  wire logic        irq_request,
	input  wire logic        serial_out_next,
	input  wire logic        diff_tx_next,
	output logic             irq_out,
	output logic             irq_oe,
	output logic             second_channel_serial_out,
	output logic             diff_tx_out,
	output logic             diff_rx_en
);

	// ==========================================================
	// Bus decode
	urs_apb_req_s req;
	logic         wr_en;
	logic         rd_en;
	logic         hit;
	logic         any_rst;
	logic         enh_en;
	logic         access;
	logic         ack_q;
	logic         ack_d;

	// One wait state: read data is registered in the first access cycle and
	// stands when pready rises; a write lands only at the pready edge
	assign req     = '{psel, penable, pwrite, paddr, pwdata};
	assign access  = req.psel && req.penable;
	assign ack_d   = access && !ack_q;
	assign wr_en   = access && ack_q && req.pwrite;
	assign rd_en   = access && !ack_q && !req.pwrite;
	assign pready  = ack_q;
	assign pslverr = access && ack_q && !hit;
	assign any_rst = srst || power_on_rst;

	function automatic logic [7:0] merge_enh(input logic [7:0] old_v, input logic [7:0] new_v,
		input logic [7:0] mask, input logic en);
		merge_enh = en ? new_v : ((old_v & mask) | (new_v & ~mask));
	endfunction

	// ==========================================================
	// Registers
	urs_regs_s  regs_q;
	urs_regs_s  regs_d;
	logic [7:0] div_low_q;
	logic [7:0] div_low_d;
	logic [7:0] div_high_q;
	logic [7:0] div_high_d;
	logic [3:0] modem_prev_q;
	logic [3:0] modem_delta_q;
	logic [3:0] modem_delta_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;

	assign enh_en = regs_q.feature[ENH_EN_BIT];

	always_comb begin
		logic [7:0] w;
		w          = req.pwdata[7:0];
		regs_d     = regs_q;
		div_low_d  = div_low_q;
		div_high_d = div_high_q;
		if (wr_en) begin
			unique case (req.paddr)
				ADDR_RESUME1:    regs_d.resume1 = w;                  // RULE1
				ADDR_RESUME2:    regs_d.resume2 = w;                  // RULE1
				ADDR_PAUSE1:     regs_d.pause1 = w;                   // RULE1
				ADDR_PAUSE2:     regs_d.pause2 = w;                   // RULE1
				ADDR_DIV_LOW:    div_low_d = w;
				ADDR_DIV_HIGH:   div_high_d = w;
				ADDR_FRAC_DIV:   if (enh_en) regs_d.frac_div = w;     // RULE7
				ADDR_INT_EN:     regs_d.int_en = merge_enh(regs_q.int_en, w, MASK_INT_EN, enh_en); // RULE7
				ADDR_INT_STAT:   regs_d.int_stat = merge_enh(regs_q.int_stat, w, MASK_INT_STAT, enh_en); // RULE7
				ADDR_FIFO_CTRL:  regs_d.fifo_ctrl = merge_enh(regs_q.fifo_ctrl, w, MASK_FIFO_CTRL, enh_en); // RULE7
				ADDR_LINE_CTRL:  regs_d.line_ctrl = w;
				ADDR_MODEM_CTRL: regs_d.modem_ctrl = merge_enh(regs_q.modem_ctrl, w, MASK_MODEM_CTL, enh_en); // RULE7
				ADDR_LINE_STAT:  regs_d.line_stat = w;
				ADDR_SCRATCH:    regs_d.scratch = w;
				ADDR_ENH_MODE:   regs_d.enh_mode = w;
				ADDR_FEATURE:    regs_d.feature = w;
				ADDR_BUS_MODE:   regs_d.bus_mode = w[0];
				default:         regs_d = regs_q;
			endcase
		end
	end

	// Delta bits set on pin change; a change beats the clearing read
	always_comb begin
		modem_delta_d = modem_delta_q;
		if (rd_en && req.paddr == ADDR_MODEM_STAT)
			modem_delta_d = 4'h0;
		modem_delta_d = modem_delta_d | (modem_prev_q ^ modem_in_pins);
	end

	// Address decode serves both directions so an unmapped write errors too
	always_comb begin
		logic [31:0] rd_v;
		rd_v = 32'h0;
		hit  = 1'b1;
		unique case (req.paddr)
			ADDR_RESUME1:    rd_v[7:0] = regs_q.resume1;      // RULE1
			ADDR_RESUME2:    rd_v[7:0] = regs_q.resume2;      // RULE1
			ADDR_PAUSE1:     rd_v[7:0] = regs_q.pause1;       // RULE1
			ADDR_PAUSE2:     rd_v[7:0] = regs_q.pause2;       // RULE1
			ADDR_DIV_LOW:    rd_v[7:0] = div_low_q;
			ADDR_DIV_HIGH:   rd_v[7:0] = div_high_q;
			ADDR_FRAC_DIV:   rd_v[7:0] = regs_q.frac_div;
			ADDR_INT_EN:     rd_v[7:0] = regs_q.int_en;
			ADDR_INT_STAT:   rd_v[7:0] = regs_q.int_stat;
			ADDR_FIFO_CTRL:  rd_v[7:0] = regs_q.fifo_ctrl;
			ADDR_LINE_CTRL:  rd_v[7:0] = regs_q.line_ctrl;
			ADDR_MODEM_CTRL: rd_v[7:0] = regs_q.modem_ctrl;
			ADDR_LINE_STAT:  rd_v[7:0] = regs_q.line_stat;
			ADDR_MODEM_STAT: rd_v[7:0] = {~modem_in_pins, modem_delta_q}; // RULE3
			ADDR_SCRATCH:    rd_v[7:0] = regs_q.scratch;
			ADDR_ENH_MODE:   rd_v[7:0] = regs_q.enh_mode;
			ADDR_FEATURE:    rd_v[7:0] = regs_q.feature;
			ADDR_BUS_MODE:   rd_v[0]   = regs_q.bus_mode;
			default:         hit = 1'b0;
		endcase
		prdata_d = rd_en ? rd_v : prdata_q;
	end

	always_ff @(posedge sys_clk) begin
		if (any_rst) begin
			regs_q <= '{resume1: RST_ZERO, resume2: RST_ZERO, pause1: RST_ZERO,
				pause2: RST_ZERO, frac_div: RST_ZERO, int_en: RST_ZERO,
				int_stat: RST_INT_STAT, fifo_ctrl: RST_ZERO, line_ctrl: RST_ZERO,
				modem_ctrl: RST_ZERO, line_stat: RST_LINE_STAT, scratch: RST_SCRATCH,
				enh_mode: RST_ENH_MODE, feature: RST_ZERO,
				// Bus style is a strap: only power-up returns it to strobe pair
				bus_mode: power_on_rst ? 1'b0 : regs_q.bus_mode}; // RULE4 RULE6 RULE7
			modem_delta_q <= 4'h0;                                      // RULE3
			prdata_q      <= 32'h0;
			ack_q         <= 1'b0;
		end else begin
			regs_q        <= regs_d;
			modem_delta_q <= modem_delta_d;
			prdata_q      <= prdata_d;
			ack_q         <= ack_d;
		end
	end

	// Previous pin levels; reloaded during reset so no false delta follows
	always_ff @(posedge sys_clk) begin
		modem_prev_q <= modem_in_pins;
	end

	// Divisor only follows power-up, never the reset pin
	always_ff @(posedge sys_clk) begin
		if (power_on_rst) begin
			div_low_q  <= RST_DIV_LOW;                                  // RULE2
			div_high_q <= RST_DIV_HIGH;                                 // RULE2
		end else begin
			div_low_q  <= div_low_d;
			div_high_q <= div_high_d;
		end
	end

	assign prdata = prdata_q;

	// ==========================================================
	// Pin states
	always_comb begin
		if (any_rst) begin
			irq_out                   = 1'b1;
			irq_oe                    = (regs_q.bus_mode == URS_BUS_CSRW);  // RULE4
			second_channel_serial_out = 1'b1;                             // RULE5
			diff_tx_out               = 1'b0;                             // RULE5
			diff_rx_en                = 1'b0;                             // RULE5
		end else begin
			irq_out                   = (regs_q.bus_mode == URS_BUS_CSRW) ? !irq_request
				: irq_request;
			irq_oe                    = 1'b1;
			second_channel_serial_out = serial_out_next;
			diff_tx_out               = diff_tx_next;
			diff_rx_en                = 1'b1;
		end
	end

	// ==========================================================
	// Checks
	AST_DIV_KEEP: assert property (@(posedge sys_clk) // RULE2
		srst && !power_on_rst && !wr_en |=> div_low_q == $past(div_low_q)
		&& div_high_q == $past(div_high_q))
		else $error("divisor changed on pin reset");
	AST_DIV_PWR: assert property (@(posedge sys_clk) // RULE2
		power_on_rst |=> div_low_q == RST_DIV_LOW && div_high_q == RST_DIV_HIGH)
		else $error("divisor not loaded at power-up");
	AST_RST_VALS: assert property (@(posedge sys_clk) // RULE6
		srst |=> regs_q.int_stat == RST_INT_STAT && regs_q.line_stat == RST_LINE_STAT
		&& regs_q.scratch == RST_SCRATCH && regs_q.enh_mode == RST_ENH_MODE)
		else $error("reset values wrong");
	AST_CHARS_CLR: assert property (@(posedge sys_clk) // RULE1
		srst |=> regs_q.resume1 == RST_ZERO && regs_q.resume2 == RST_ZERO
		&& regs_q.pause1 == RST_ZERO && regs_q.pause2 == RST_ZERO)
		else $error("flow chars not cleared");
	AST_DELTA_CLR: assert property (@(posedge sys_clk) // RULE3
		srst |=> modem_delta_q == 4'h0)
		else $error("modem deltas not cleared");
	AST_IRQ_FLOAT: assert property (@(posedge sys_clk) // RULE4
		any_rst && regs_q.bus_mode == URS_BUS_STROBE |-> !irq_oe)
		else $error("interrupt driven in strobe style reset");
	AST_IRQ_HIGH: assert property (@(posedge sys_clk) // RULE4
		any_rst && regs_q.bus_mode == URS_BUS_CSRW |-> irq_oe && irq_out)
		else $error("interrupt not driven high in chip-select style reset");
	AST_PINS_RST: assert property (@(posedge sys_clk) // RULE5
		any_rst |-> second_channel_serial_out && !diff_tx_out && !diff_rx_en)
		else $error("pin reset state wrong");
	AST_ENH_LOCK: assert property (@(posedge sys_clk) disable iff (any_rst) // RULE7
		!enh_en |=> regs_q.int_en[7:4] == $past(regs_q.int_en[7:4])
		&& regs_q.int_stat[5:4] == $past(regs_q.int_stat[5:4])
		&& regs_q.fifo_ctrl[5:4] == $past(regs_q.fifo_ctrl[5:4])
		&& regs_q.modem_ctrl[7:5] == $past(regs_q.modem_ctrl[7:5])
		&& regs_q.frac_div == $past(regs_q.frac_div))
		else $error("enhanced bits changed while locked");

endmodule
`default_nettype wire

// >>> testbench/tb_uart_reset_state_and_flow_chars.sv
// Self-checking bench for the reset-state register bank
`timescale 1ns/1ps
`default_nettype none
module tb_uart_reset_state_and_flow_chars;
	import urs_pkg::*;
	logic         sys_clk, srst, por, irq_req, ser_nx, diff_nx, pready, pslverr;
	logic         irq_out, irq_oe, ser_out, diff_tx, diff_rx_en, err;
	logic [3:0]   pins;
	logic [31:0]  prdata, rd;
	urs_apb_req_s req;
	int           err_count, total_checks, cycles;

	urs_bank u_dut (.sys_clk(sys_clk), .srst(srst), .power_on_rst(por), .psel(req.psel),
		.penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .modem_in_pins(pins),
		.irq_request(irq_req), .serial_out_next(ser_nx), .diff_tx_next(diff_nx),
		.irq_out(irq_out), .irq_oe(irq_oe), .second_channel_serial_out(ser_out),
		.diff_tx_out(diff_tx), .diff_rx_en(diff_rx_en));
	urs_host u_host (.sys_clk(sys_clk), .req(req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// ==========================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.xfer(1'b1, a, {24'h0, d}, rd, err);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		u_host.xfer(1'b0, a, 32'h0, rd, err);
		chk(rd, {24'h0, e});
	endtask
	task automatic pulse(input logic pin);
		@(posedge sys_clk);
		if (pin) srst <= 1'b1; else por <= 1'b1;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		por  <= 1'b0;
	endtask
	task automatic stop_test;
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset_vals;
		logic [7:0] a [17] = '{ADDR_RESUME1, ADDR_RESUME2, ADDR_PAUSE1, ADDR_PAUSE2,
			ADDR_DIV_LOW, ADDR_DIV_HIGH, ADDR_FRAC_DIV, ADDR_INT_EN, ADDR_INT_STAT,
			ADDR_FIFO_CTRL, ADDR_LINE_CTRL, ADDR_MODEM_CTRL, ADDR_LINE_STAT,
			ADDR_SCRATCH, ADDR_ENH_MODE, ADDR_FEATURE, ADDR_BUS_MODE};
		logic [7:0] e [17] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
			8'h01, 8'h00, 8'h00, 8'h00, 8'h60, 8'hff, 8'h80, 8'h00, 8'h00};
		foreach (a[i]) rchk(a[i], e[i]);
		rchk(ADDR_MODEM_STAT, 8'h50);
		pins <= 4'h3;
		pulse(1'b1);
		rchk(ADDR_MODEM_STAT, 8'hc0);
	endtask
	task automatic t_chars;
		logic [7:0] a [4] = '{ADDR_RESUME1, ADDR_RESUME2, ADDR_PAUSE1, ADDR_PAUSE2};
		logic [7:0] d [4] = '{8'hff, 8'h11, 8'h80, 8'h13};
		foreach (a[i]) wr(a[i], d[i]);
		u_host.xfer(1'b1, 8'h80, 32'h5a, rd, err);
		chk(err, 32'h1);
		foreach (a[i]) rchk(a[i], d[i]);
		pulse(1'b1);
		foreach (a[i]) rchk(a[i], 8'h00);
	endtask
	task automatic t_divisor;
		wr(ADDR_DIV_LOW, 8'h37);
		wr(ADDR_DIV_HIGH, 8'h12);
		pulse(1'b1);
		rchk(ADDR_DIV_LOW, 8'h37);
		rchk(ADDR_DIV_HIGH, 8'h12);
		pulse(1'b0);
		rchk(ADDR_DIV_LOW, 8'h01);
		rchk(ADDR_DIV_HIGH, 8'h00);
	endtask
	task automatic t_enh;
		wr(ADDR_INT_EN, 8'hff);
		wr(ADDR_FRAC_DIV, 8'h5a);
		rchk(ADDR_INT_EN, 8'h0f);
		rchk(ADDR_FRAC_DIV, 8'h00);
		wr(ADDR_FEATURE, 8'h10);
		wr(ADDR_INT_EN, 8'hff);
		wr(ADDR_FRAC_DIV, 8'h5a);
		wr(ADDR_FEATURE, 8'h00);
		wr(ADDR_INT_EN, 8'h00);
		wr(ADDR_FRAC_DIV, 8'ha5);
		rchk(ADDR_INT_EN, 8'hf0);
		rchk(ADDR_FRAC_DIV, 8'h5a);
		pulse(1'b1);
		rchk(ADDR_INT_EN, 8'h00);
		rchk(ADDR_FRAC_DIV, 8'h00);
	endtask
	task automatic t_pins;
		ser_nx  <= 1'b0;
		diff_nx <= 1'b1;
		@(posedge sys_clk);
		srst <= 1'b1;
		#1;
		chk({irq_oe, irq_out}, 32'h1);
		chk({ser_out, diff_tx, diff_rx_en}, 32'h4);
		@(posedge sys_clk);
		srst <= 1'b0;
		#1;
		chk({irq_oe, irq_out}, 32'h2);
		chk({ser_out, diff_tx, diff_rx_en}, 32'h3);
		wr(ADDR_BUS_MODE, 8'h01);
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (2) begin
			#1;
			chk({irq_oe, irq_out}, 32'h3);
			@(posedge sys_clk);
		end
		srst <= 1'b0;
		@(posedge sys_clk);
		irq_req <= 1'b1;
		#1;
		chk({irq_oe, irq_out}, 32'h2);
		rchk(ADDR_BUS_MODE, 8'h01);
	endtask

	// ==========================================================
	// Clock, reset, timeout and main sequence
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end
	initial begin
		{srst, por} = 2'b11;
		{irq_req, ser_nx, diff_nx} = 3'b010;
		pins = 4'ha;
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		por  <= 1'b0;
		t_reset_vals();
		t_chars();
		t_divisor();
		t_enh();
		t_pins();
		stop_test();
	end
endmodule
`default_nettype wire

// >>> testbench/urs_host.sv
// Host processor model driving the register bank over APB
`timescale 1ns/1ps
`default_nettype none
module urs_host
	import urs_pkg::*;
(
	input  wire logic        sys_clk,
	output var urs_apb_req_s req,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial req = '0;
	// ==========================================================
	// One transfer; read data and error are taken at the pready edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge sys_clk);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= wr;
		req.paddr   <= a;
		req.pwdata  <= d;
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		// Released address and data lines show the inverse of their last value; pwrite holds
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
		req.paddr   <= ~a;
		req.pwdata  <= ~d;
	endtask
endmodule
`default_nettype wire
